// ===== cee_defines.vh
// Constants for the core event entry and return unit
`ifndef CEE_DEFINES_VH
`define CEE_DEFINES_VH

// ****************************************************************
// Status register layout
// ****************************************************************
`define CEE_SR_W 16
`define CEE_SR_GM 1
`define CEE_SR_I0M 2
`define CEE_SR_I1M 3
`define CEE_SR_I2M 4
`define CEE_SR_I3M 5
`define CEE_SR_EM 6
`define CEE_SR_DM 7
`define CEE_SR_MODE_LO 8
`define CEE_SR_MODE_HI 10
`define CEE_SR_RESET 16'h00FE

// ****************************************************************
// Execution modes
// ****************************************************************
`define CEE_MODE_APP 3'h0
`define CEE_MODE_SUP 3'h1
`define CEE_MODE_IRQ_LEVEL_ZERO 3'h2
`define CEE_MODE_IRQ_LEVEL_ONE 3'h3
`define CEE_MODE_IRQ_LEVEL_TWO 3'h4
`define CEE_MODE_IRQ_LEVEL_THREE 3'h5
`define CEE_MODE_EXC 3'h6
`define CEE_MODE_NMI 3'h7

// ****************************************************************
// Addresses and stack
// ****************************************************************
`define CEE_RESET_PC 32'h80000000
`define CEE_EVBA 32'h80000000
`define CEE_OFS_UNREC 32'h00000000
`define CEE_OFS_TLBMH 32'h00000004
`define CEE_OFS_BUSERR 32'h00000008
`define CEE_OFS_NMI 32'h00000010
`define CEE_OFS_EXC 32'h00000020
`define CEE_OFS_SCALL 32'h00000100
`define CEE_SP_RESET 32'h00008000
`define CEE_WORD 32'h00000004
`define CEE_CNT_W 3
`define CEE_SHORT_LAST 3'h1
`define CEE_LONG_LAST 3'h7
`define CEE_CNT_ZERO 3'h0
`define CEE_CNT_ONE 3'h1
`define CEE_SAVE_SR 3'h0
`define CEE_SAVE_PC 3'h1
`define CEE_SAVE_LR 3'h2
`define CEE_SAVE_R8 3'h3

`endif

// ===== cee_event_chk.sv
// Checker for the event entry and return unit
`timescale 1ns/1ps
`include "cee_defines.vh"
module cee_event_chk (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Requests
	input wire nmi_req,
	input wire unrec_req,
	input wire tlb_mhit_req,
	input wire bus_err_req,
	input wire debug_req,
	// Core state
	input wire busy,
	input wire [15:0] status,
	input wire [31:0] pc,
	input wire pc_load,
	input wire stack_we,
	input wire [2:0] reg_bank,
	input wire debug_mode,
	input wire [8:0] event_ack
);
	// One clock domain, so one clocking and one disable serve all
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);
	// ********
	// Assertions
	// ********
	one_ack_a: assert property ($onehot0(event_ack))
		else $error("two events acknowledged");
	reset_pc_a: assert property ($fell(rst) |-> pc == `CEE_RESET_PC)
		else $error("wrong fetch address after reset");
	nmi_take_a: assert property (nmi_req && !busy && !event_ack && !debug_req &&
		!(unrec_req | tlb_mhit_req | bus_err_req) |=> event_ack[3]) else $error("nmi refused");
	crit_order_a: assert property (event_ack[3] |->
		!$past(unrec_req) && !$past(tlb_mhit_req) && !$past(bus_err_req)) else $error("order");
	exc_mask_a: assert property (event_ack[4] |-> !$past(status[`CEE_SR_EM]))
		else $error("masked exception taken");
	exc_sets_a: assert property (event_ack[4] |-> status[`CEE_SR_EM] && status[`CEE_SR_GM])
		else $error("exception masks not set");
	irq_mask_a: assert property (event_ack[6] |-> !$past(status[`CEE_SR_I2M]))
		else $error("masked interrupt taken");
	irq_masks_a: assert property (event_ack[6] |-> status[4:2] == 3'h7)
		else $error("lower masks not set");
	bank_mode_a: assert property (reg_bank == status[10:8])
		else $error("bank differs from mode");
	nmi_pc_a: assert property (event_ack[3] |-> ##2 pc_load && pc == `CEE_EVBA + `CEE_OFS_NMI)
		else $error("nmi handler not loaded");
	save_push_a: assert property (event_ack != 9'h000 |-> ##[0:2] stack_we)
		else $error("no context push");
	dbg_gate_a: assert property ($rose(debug_mode) |-> !$past(status[`CEE_SR_DM]))
		else $error("masked debug entry");
	// Main scenarios
	nmi_seen_c: cover property (event_ack[3]);
	irq_seen_c: cover property (event_ack[6]);
	dbg_seen_c: cover property ($rose(debug_mode));
endmodule
bind cee_event_unit cee_event_chk u_chk (.core_clk(core_clk), .rst(rst), .nmi_req(nmi_req),
	.unrec_req(unrec_req), .tlb_mhit_req(tlb_mhit_req), .bus_err_req(bus_err_req),
	.debug_req(debug_req), .busy(busy), .status(status), .pc(pc), .pc_load(pc_load),
	.stack_we(stack_we), .reg_bank(reg_bank), .debug_mode(debug_mode), .event_ack(event_ack));

// ===== cee_event_unit.v
// Event acceptance, context save, handler dispatch and return for the core
`timescale 1ns/1ps
`include "cee_defines.vh"
module cee_event_unit (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Event requests, held until acknowledged
	input wire nmi_req,
	input wire unrec_req,
	input wire tlb_mhit_req,
	input wire bus_err_req,
	input wire exc_req,
	input wire [3:0] irq_req,
	input wire [31:0] irq_handler,
	input wire debug_req,
	// Instruction stream events
	input wire scall_exec,
	input wire rets_exec,
	input wire rete_exec,
	input wire [31:0] next_pc_in,
	// Core register values to save
	input wire [31:0] lr_in,
	input wire [159:0] r8_r12_in,
	// Software write of the status register
	input wire sr_we,
	input wire [15:0] sr_wdata,
	// Stack memory port
	output reg stack_we,
	output reg stack_re,
	output reg [31:0] stack_addr,
	output reg [31:0] stack_wdata,
	input wire [31:0] stack_rdata,
	// Restored registers toward the register file
	output reg restore_we,
	output reg [2:0] restore_idx,
	output reg [31:0] restore_data,
	// Core state
	output reg [15:0] status,
	output reg [31:0] pc,
	output reg [31:0] sp,
	output wire [2:0] reg_bank,
	output reg pc_load,
	output reg debug_mode,
	output wire busy,
	// Acknowledges, one cycle each
	output reg [8:0] event_ack
);

	// ****************************************************************
	// States
	// ****************************************************************
	localparam ST_IDLE = 4'b0001;
	localparam ST_PUSH = 4'b0010;
	localparam ST_POP = 4'b0100;
	localparam ST_LOAD = 4'b1000;

	reg [3:0] state;
	reg [2:0] cnt;
	reg [2:0] last;
	reg [2:0] new_mode;
	reg [31:0] target;
	reg [31:0] save_pc;
	reg [31:0] save_lr;
	reg [159:0] save_regs;
	reg [15:0] save_sr;
	reg [31:0] rd_pc;
	reg rd_valid;
	reg [2:0] rd_idx;
	reg [15:0] next_status;

	// Event selection
	reg sel_valid;
	reg [8:0] sel_ack;
	reg [2:0] sel_mode;
	reg [31:0] sel_addr;
	reg sel_irq;
	reg sel_exc;

	wire [2:0] cur_mode = status[`CEE_SR_MODE_HI:`CEE_SR_MODE_LO];
	wire in_irq = (cur_mode >= `CEE_MODE_IRQ_LEVEL_ZERO) && (cur_mode <= `CEE_MODE_IRQ_LEVEL_THREE);
	assign reg_bank = cur_mode;
	assign busy = (state != ST_IDLE);

	// ****************************************************************
	// Priority pick
	// ****************************************************************
	// Fixed order; masked sources are skipped, critical ones never are.
	// The pick is purely combinational so the winner is known in the
	// same cycle that the sequencer looks at it; a source that drops its
	// request before this point is simply not seen again.
	always @*
	begin
		sel_valid = 1'b1;
		sel_ack = 9'h000;
		sel_mode = `CEE_MODE_NMI;
		sel_addr = `CEE_EVBA;
		sel_irq = 1'b0;
		sel_exc = 1'b0;
		if (unrec_req)
		begin
			sel_ack = 9'h001;
			sel_addr = `CEE_EVBA + `CEE_OFS_UNREC;
			sel_exc = 1'b1;
		end
		else if (tlb_mhit_req)
		begin
			sel_ack = 9'h002;
			sel_addr = `CEE_EVBA + `CEE_OFS_TLBMH;
			sel_exc = 1'b1;
		end
		else if (bus_err_req)
		begin
			sel_ack = 9'h004;
			sel_addr = `CEE_EVBA + `CEE_OFS_BUSERR;
			sel_exc = 1'b1;
		end
		else if (nmi_req)
		begin
			sel_ack = 9'h008;
			sel_addr = `CEE_EVBA + `CEE_OFS_NMI;
		end
		else if (exc_req && !status[`CEE_SR_EM] && !status[`CEE_SR_GM])
		begin
			sel_ack = 9'h010;
			sel_mode = `CEE_MODE_EXC;
			sel_addr = `CEE_EVBA + `CEE_OFS_EXC;
			sel_exc = 1'b1;
		end
		else if (irq_req[3] && !status[`CEE_SR_I3M] && !status[`CEE_SR_GM])
		begin
			sel_ack = 9'h020;
			sel_mode = `CEE_MODE_IRQ_LEVEL_THREE;
			sel_addr = irq_handler;
			sel_irq = 1'b1;
		end
		else if (irq_req[2] && !status[`CEE_SR_I2M] && !status[`CEE_SR_GM])
		begin
			sel_ack = 9'h040;
			sel_mode = `CEE_MODE_IRQ_LEVEL_TWO;
			sel_addr = irq_handler;
			sel_irq = 1'b1;
		end
		else if (irq_req[1] && !status[`CEE_SR_I1M] && !status[`CEE_SR_GM])
		begin
			sel_ack = 9'h080;
			sel_mode = `CEE_MODE_IRQ_LEVEL_ONE;
			sel_addr = irq_handler;
			sel_irq = 1'b1;
		end
		else if (irq_req[0] && !status[`CEE_SR_I0M] && !status[`CEE_SR_GM])
		begin
			sel_ack = 9'h100;
			sel_mode = `CEE_MODE_IRQ_LEVEL_ZERO;
			sel_addr = irq_handler;
			sel_irq = 1'b1;
		end
		else
		begin
			sel_valid = 1'b0;
		end
	end

	// ****************************************************************
	// Mask update on acceptance
	// ****************************************************************
	// Equal and lower levels are masked; critical sources ignore masks.
	// Software may clear these bits inside a handler to allow nesting,
	// so nothing here assumes that the masks stay set until return.
	always @*
	begin
		next_status = status;
		next_status[`CEE_SR_MODE_HI:`CEE_SR_MODE_LO] = sel_mode;
		if (sel_exc || sel_ack[3])
		begin
			next_status[`CEE_SR_EM] = 1'b1;
			next_status[`CEE_SR_GM] = 1'b1;
			next_status[`CEE_SR_I3M] = 1'b1;
			next_status[`CEE_SR_I2M] = 1'b1;
			next_status[`CEE_SR_I1M] = 1'b1;
			next_status[`CEE_SR_I0M] = 1'b1;
		end
		if (sel_ack[5])
			next_status[`CEE_SR_I3M] = 1'b1;
		if (sel_ack[5] | sel_ack[6])
			next_status[`CEE_SR_I2M] = 1'b1;
		if (sel_ack[5] | sel_ack[6] | sel_ack[7])
			next_status[`CEE_SR_I1M] = 1'b1;
		if (sel_irq)
			next_status[`CEE_SR_I0M] = 1'b1;
	end

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// No new event is looked at until the sequence ends, so save and
	// dispatch cannot be split by a second request.
	// Debug entry is checked ahead of events; an event pending in the
	// same cycle waits one cycle and is then picked up.
	always @(posedge core_clk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			cnt <= `CEE_CNT_ZERO;
			last <= `CEE_CNT_ZERO;
			new_mode <= `CEE_MODE_APP;
			target <= `CEE_RESET_PC;
			save_pc <= 32'h00000000;
			save_lr <= 32'h00000000;
			save_regs <= 160'h0;
			save_sr <= 16'h0000;
			rd_pc <= 32'h00000000;
			rd_valid <= 1'b0;
			rd_idx <= `CEE_CNT_ZERO;
			status <= `CEE_SR_RESET;
			pc <= `CEE_RESET_PC;
			sp <= `CEE_SP_RESET;
			pc_load <= 1'b1;
			debug_mode <= 1'b0;
			event_ack <= 9'h000;
			stack_we <= 1'b0;
			stack_re <= 1'b0;
			stack_addr <= 32'h00000000;
			stack_wdata <= 32'h00000000;
			restore_we <= 1'b0;
			restore_idx <= `CEE_CNT_ZERO;
			restore_data <= 32'h00000000;
		end
		else
		begin
			event_ack <= 9'h000;
			pc_load <= 1'b0;
			stack_we <= 1'b0;
			stack_re <= 1'b0;
			restore_we <= 1'b0;
			rd_valid <= stack_re;
			// cnt has stepped on since the read was issued, hence the extra one
			rd_idx <= last - cnt + `CEE_CNT_ONE;
			// Restored words arrive one cycle after their read
			if (rd_valid)
			begin
				if (rd_idx == `CEE_SAVE_SR)
					save_sr <= stack_rdata[15:0];
				else if (rd_idx == `CEE_SAVE_PC)
					rd_pc <= stack_rdata;
				else
				begin
					restore_we <= 1'b1;
					restore_idx <= rd_idx - `CEE_SAVE_LR;
					restore_data <= stack_rdata;
				end
			end
			case (state)
				ST_IDLE:
				begin
					if (sr_we)
						status <= sr_wdata;
					if (debug_req && !status[`CEE_SR_DM] && !debug_mode)
						debug_mode <= 1'b1;
					else if (sel_valid)
					begin
						event_ack <= sel_ack;
						save_sr <= status;
						save_pc <= next_pc_in;
						save_lr <= lr_in;
						save_regs <= r8_r12_in;
						status <= next_status;
						target <= sel_addr;
						last <= sel_irq ? `CEE_LONG_LAST : `CEE_SHORT_LAST;
						cnt <= `CEE_CNT_ZERO;
						state <= ST_PUSH;
					end
					else if (scall_exec)
					begin
						save_sr <= status;
						save_pc <= next_pc_in;
						status[`CEE_SR_MODE_HI:`CEE_SR_MODE_LO] <= `CEE_MODE_SUP;
						target <= `CEE_EVBA + `CEE_OFS_SCALL;
						last <= `CEE_SHORT_LAST;
						cnt <= `CEE_CNT_ZERO;
						state <= ST_PUSH;
					end
					else if (rete_exec || rets_exec)
					begin
						last <= (rete_exec && in_irq) ? `CEE_LONG_LAST : `CEE_SHORT_LAST;
						cnt <= `CEE_CNT_ZERO;
						state <= ST_POP;
					end
				end
				ST_PUSH:
				begin
					// Full descending stack; overflow is left to software
					// One word per cycle: status first so a partial frame
					// still holds the mode to return to.
					stack_we <= 1'b1;
					stack_addr <= sp - `CEE_WORD;
					sp <= sp - `CEE_WORD;
					if (cnt == `CEE_SAVE_SR)
						stack_wdata <= {16'h0000, save_sr};
					else if (cnt == `CEE_SAVE_PC)
						stack_wdata <= save_pc;
					else if (cnt == `CEE_SAVE_LR)
						stack_wdata <= save_lr;
					else
						stack_wdata <= save_regs[(cnt - `CEE_SAVE_R8) * 32 +: 32];
					cnt <= cnt + `CEE_CNT_ONE;
					if (cnt == last)
					begin
						pc <= target;
						pc_load <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_POP:
				begin
					// Pop order is the reverse of push order
					stack_re <= 1'b1;
					stack_addr <= sp;
					sp <= sp + `CEE_WORD;
					cnt <= cnt + `CEE_CNT_ONE;
					if (cnt == last)
						state <= ST_LOAD;
				end
				ST_LOAD:
				begin
					// Wait for the final word, then resume the saved context.
					// Status and address change in one edge so the old mode
					// never runs at the return address.
					if (!stack_re && !rd_valid)
					begin
						status <= save_sr;
						pc <= rd_pc;
						pc_load <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default:
				begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************************************
	// Pop index mapping
	// ****************************************************************
	// The stack is full descending, so the first pop returns the word
	// pushed last. The read index is mirrored against the frame length,
	// so index 0 is always the saved status and index 1 the return
	// address, whatever the length of the frame. Register words come
	// back from R12 down to R8 and then the link register.
	// Limitation: a frame that software has rewritten on the stack is
	// restored as found; no check of its contents is made here.

endmodule

// ===== cee_event_unit_tb_top.sv
// Self-checking testbench for the event entry and return unit
`timescale 1ns/1ps
`include "cee_defines.vh"
module cee_event_unit_tb_top;
	logic core_clk = 1'b0, rst = 1'b1, debug_req = 1'b0, sr_we = 1'b0;
	logic scall_exec = 1'b0, rets_exec = 1'b0, rete_exec = 1'b0;
	logic [8:0] raise = 9'h000, req, event_ack;
	logic [31:0] irq_handler = 32'h0, next_pc_in = 32'h0, lr_in = 32'h0, lfsr = 32'hF;
	logic [159:0] r8_r12_in = 160'h0, exp_regs = 160'h0;
	logic [15:0] sr_wdata = 16'h0, status, exp_sr;
	logic stack_we, stack_re, restore_we, pc_load, debug_mode, busy;
	logic [31:0] stack_addr, stack_wdata, stack_rdata, restore_data, pc, sp, exp_pc;
	logic [31:0] exp_lr = 32'h0;
	logic [2:0] restore_idx, reg_bank;
	int miscompares = 0, total_checks = 0, n_push = 0, n_pop = 0, i;
	int p_base = 0, r_base = 0;
	// Clock at 10 MHz
	always #50 core_clk = ~core_clk;
	cee_event_unit u_dut (.core_clk(core_clk), .rst(rst), .nmi_req(req[3]),
		.unrec_req(req[0]), .tlb_mhit_req(req[1]), .bus_err_req(req[2]), .exc_req(req[4]),
		.irq_req({req[5], req[6], req[7], req[8]}), .irq_handler(irq_handler),
		.debug_req(debug_req), .scall_exec(scall_exec), .rets_exec(rets_exec),
		.rete_exec(rete_exec), .next_pc_in(next_pc_in), .lr_in(lr_in), .r8_r12_in(r8_r12_in),
		.sr_we(sr_we), .sr_wdata(sr_wdata), .stack_we(stack_we), .stack_re(stack_re),
		.stack_addr(stack_addr), .stack_wdata(stack_wdata), .stack_rdata(stack_rdata),
		.restore_we(restore_we), .restore_idx(restore_idx), .restore_data(restore_data),
		.status(status), .pc(pc), .sp(sp), .reg_bank(reg_bank), .pc_load(pc_load),
		.debug_mode(debug_mode), .busy(busy), .event_ack(event_ack));
	cee_far_model u_far (.core_clk(core_clk), .rst(rst), .raise(raise), .event_ack(event_ack),
		.req(req), .stack_we(stack_we), .stack_re(stack_re), .stack_addr(stack_addr),
		.stack_wdata(stack_wdata), .stack_rdata(stack_rdata));
	// Count stack pushes and register restores per operation
	always @(posedge core_clk)
	begin
		n_push <= n_push + (stack_we === 1'b1);
		n_pop <= n_pop + (restore_we === 1'b1);
	end
	// ********
	// Helpers
	// ********
	function logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	// Restore index 0 is the link register, 1 to 5 are R8 to R12
	function logic [31:0] exp_restore(input logic [2:0] idx);
		if (idx == 3'h0)
			return exp_lr;
		return exp_regs[(idx - 3'h1) * 32 +: 32];
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task report_and_stop;
		$display("Checks %0d, mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Every restored register must carry what was saved for it
	always @(posedge core_clk)
	begin
		if (restore_we === 1'b1)
			check(restore_data, exp_restore(restore_idx));
	end
	// A lost handler load would hang the run, so the wait is bounded
	task wait_load;
		repeat (40)
		begin
			@(posedge core_clk);
			#1;
			if (pc_load === 1'b1)
				return;
		end
		miscompares++;
		report_and_stop();
	endtask
	task sr_write(input logic [15:0] v);
		@(posedge core_clk);
		sr_we <= 1'b1;
		sr_wdata <= v;
		@(posedge core_clk);
		sr_we <= 1'b0;
		#1;
	endtask
	// Fresh random context, then an event or a supervisor call; zero handler means irq
	task take(input logic [8:0] bits, input bit call, input logic [31:0] hnd, input int pushes);
		@(posedge core_clk);
		lfsr = lfsr_next(lfsr);
		next_pc_in <= lfsr & 32'hFFFFFFFE;
		irq_handler <= ~lfsr;
		lr_in <= lfsr ^ 32'h5A5A5A5A;
		r8_r12_in <= {lfsr ^ 32'h4, lfsr ^ 32'h3, lfsr ^ 32'h2, lfsr ^ 32'h1, lfsr};
		exp_pc = lfsr & 32'hFFFFFFFE;
		exp_lr = lfsr ^ 32'h5A5A5A5A;
		exp_regs = {lfsr ^ 32'h4, lfsr ^ 32'h3, lfsr ^ 32'h2, lfsr ^ 32'h1, lfsr};
		exp_sr = status;
		p_base = n_push;
		if (call)
			scall_exec <= 1'b1;
		else
			raise <= bits;
		@(posedge core_clk);
		raise <= 9'h000;
		scall_exec <= 1'b0;
		wait_load();
		// The last push shows beside the load, so let the counter take it
		@(posedge core_clk);
		#1;
		check(pc, hnd != 32'h0 ? hnd : ~lfsr);
		check(n_push - p_base, pushes);
	endtask
	task ret(input bit sup, input int pops);
		@(posedge core_clk);
		r_base = n_pop;
		if (sup)
			rets_exec <= 1'b1;
		else
			rete_exec <= 1'b1;
		@(posedge core_clk);
		rets_exec <= 1'b0;
		rete_exec <= 1'b0;
		wait_load();
		check(status, exp_sr);
		check(pc, exp_pc);
		check(n_pop - r_base, pops);
		check(sp, `CEE_SP_RESET);
	endtask
	// ********
	// Main sequence
	// ********
	initial
	begin
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		#1;
		check(pc, `CEE_RESET_PC);
		check(status, `CEE_SR_RESET);
		@(posedge core_clk);
		debug_req <= 1'b1;
		repeat (4) @(posedge core_clk);
		debug_req <= 1'b0;
		check(debug_mode, 1'b0);
		// Masks up: the NMI passes, the exception stays pending until unmasked
		take(9'h018, 0, `CEE_EVBA + `CEE_OFS_NMI, 2);
		check(status[10:8], `CEE_MODE_NMI);
		ret(0, 0);
		repeat (4) @(posedge core_clk);
		check(req[4], 1'b1);
		sr_write(16'h0000);
		exp_sr = 16'h0000;
		wait_load();
		check(pc, `CEE_EVBA + `CEE_OFS_EXC);
		check({status[`CEE_SR_EM], status[`CEE_SR_GM]}, 2'b11);
		ret(0, 0);
		// Critical sources ignore every mask and have their own entries
		sr_write(`CEE_SR_RESET);
		for (i = 0; i < 3; i++)
		begin
			take(9'h001 << i, 0, `CEE_EVBA + `CEE_WORD * i, 2);
			ret(0, 0);
		end
		// Two levels at once: the higher first, the lower after the return
		sr_write(16'h0000);
		take(9'h0C0, 0, 32'h0, 8);
		check(status[10:2], {`CEE_MODE_IRQ_LEVEL_TWO, 6'h07});
		check(reg_bank, `CEE_MODE_IRQ_LEVEL_TWO);
		ret(0, 6);
		wait_load();
		check(status[10:8], `CEE_MODE_IRQ_LEVEL_ONE);
		ret(0, 6);
		take(9'h000, 1, `CEE_EVBA + `CEE_OFS_SCALL, 2);
		ret(1, 0);
		// Debug entry once its mask is down
		sr_write(16'h0000);
		@(posedge core_clk);
		debug_req <= 1'b1;
		for (i = 0; i < 10 && debug_mode !== 1'b1; i++)
			@(posedge core_clk);
		check(debug_mode, 1'b1);
		report_and_stop();
	end
endmodule

// ===== cee_far_model.sv
// Behavioural event sources and system stack memory facing the unit
`timescale 1ns/1ps
module cee_far_model (
	// Clock and reset
	input wire core_clk,
	input wire rst,
	// Event requests
	input wire [8:0] raise,
	input wire [8:0] event_ack,
	output logic [8:0] req,
	// Stack memory port
	input wire stack_we,
	input wire stack_re,
	input wire [31:0] stack_addr,
	input wire [31:0] stack_wdata,
	output logic [31:0] stack_rdata = 32'h5A5A5A5A
);
	logic [31:0] mem [logic [31:0]];
	// A request stays up until its own acknowledge, since the unit latches nothing
	always @(posedge core_clk)
	begin
		req <= rst ? 9'h000 : (req | raise) & ~event_ack;
	end
	// Unbounded stack gives every save room; read data is valid for one cycle only
	always @(posedge core_clk)
	begin
		if (stack_we)
			mem[stack_addr] = stack_wdata;
		stack_rdata <= (stack_re && mem.exists(stack_addr)) ? mem[stack_addr] : ~stack_rdata;
	end
endmodule
